/* File: sim/cst_host.sv */
`timescale 1ns/1ps
// ****
// Host side register master
// ****
module cst_host (
  output logic [7:0] addr_out,
  output logic write_out,
  output logic [7:0] wdata_out,
  output logic reg_reset_out
);
  // Idle bus from time zero
  initial begin
    addr_out = 8'h00;
    write_out = 1'b0;
    wdata_out = 8'h00;
    reg_reset_out = 1'b0;
  end
  // One cycle request, called at the rising edge; the next call ends it
  task op(input logic [7:0] a, input logic w, input logic [7:0] d, input logic r);
    addr_out <= a;
    write_out <= w;
    wdata_out <= d;
    reg_reset_out <= r;
  endtask : op
endmodule : cst_host

/* File: sim/cst_regs_monitor.sv */
`timescale 1ns/1ps
// ****
// Port checker
// ****
module cst_regs_monitor (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_write_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic detect_done_in,
  input wire logic detect_restart_in,
  input wire logic [6:0] detect_reserved_in,
  input wire logic watchdog_expire_in,
  input wire logic register_reset_in,
  input wire logic [1:0] current_monitor_select_in,
  input wire logic [1:0] charge_voltage_trim_out,
  input wire logic trickle_current_select_out,
  input wire logic [1:0] input_voltage_limit_offset_out,
  input wire logic status_pin_out,
  input wire logic status_pin_oe_n_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // Enabled edge with no clearing pulse, so a write lands
  wire quiet = clk_en_in && !watchdog_expire_in && !register_reset_in;
  sequence s_wr;
    quiet && reg_write_in && reg_addr_in == 8'h0F;
  endsequence
  chk_wd_keep: assert property (clk_en_in && watchdog_expire_in && !register_reset_in
    |=> charge_voltage_trim_out == 0 && !trickle_current_select_out
    && $stable(input_voltage_limit_offset_out)) else $error("watchdog clear wrong");
  chk_rst_clear: assert property (clk_en_in && register_reset_in
    |=> charge_voltage_trim_out == 0 && input_voltage_limit_offset_out == 0)
    else $error("register reset wrong");
  chk_fields_load: assert property (s_wr |=> charge_voltage_trim_out == $past(reg_wdata_in[7:6])
    && trickle_current_select_out == $past(reg_wdata_in[4])) else $error("fields wrong");
  chk_read_back: assert property (s_wr ##1 (quiet && reg_addr_in == 8'h0F)
    |=> reg_rdata_out == $past(reg_wdata_in, 2)) else $error("read back wrong");
  chk_done_read: assert property (clk_en_in && detect_done_in ##1
    clk_en_in && reg_addr_in == 8'h0E |=> reg_rdata_out[7]) else $error("done flag low");
  chk_restart_read: assert property (clk_en_in && detect_restart_in && !detect_done_in ##1
    clk_en_in && reg_addr_in == 8'h0E |=> !reg_rdata_out[7]) else $error("flag not cleared");
  chk_resv_read: assert property (clk_en_in && reg_addr_in == 8'h0E
    |=> reg_rdata_out[6:0] == $past(detect_reserved_in)) else $error("reserved bits wrong");
  chk_pin_low: assert property (!status_pin_out) else $error("pin driven high");
  chk_led_on: assert property ((s_wr and reg_wdata_in[3:2] == 2'h1) ##1
    quiet && current_monitor_select_in == 2'h1 |-> ##[1:3] !status_pin_oe_n_out)
    else $error("led not on");
endmodule : cst_regs_monitor

/* File: sim/tb_charger_status_tuning_regs.sv */
`timescale 1ns/1ps
module tb_charger_status_tuning_regs;
  logic clock_in = 0, rst_n_in = 0, clk_en_in = 1, detect_done_in = 0, detect_restart_in = 0;
  logic watchdog_expire_in = 0, flag = 1'bx, reg_write_in, register_reset_in;
  logic status_pin_out, status_pin_oe_n_out, trickle_current_select_out;
  logic [1:0] current_monitor_select_in = 0, charge_voltage_trim_out;
  logic [1:0] input_voltage_limit_offset_out;
  logic [6:0] detect_reserved_in = 0, trickle_ma_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, tun = 0, rd = 0;
  logic signed [5:0] trim_mv_out;
  logic [13:0] offset_mv_out;
  logic [31:0] x;
  wire [4:0] fields = {charge_voltage_trim_out, trickle_current_select_out,
    input_voltage_limit_offset_out};
  int errors = 0, n_checks = 0, seed = 32'h81C5, cnt;
  int tm[4] = '{0, 8, -8, -16};
  int om[4] = '{3900, 5900, 7500, 10500};
  int led[5] = '{0, 16, 8, 4, 0};
`define CHK(n, e, g) n_checks++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s exp %0d got %0d", n, e, g); end
  initial forever #25 clock_in = ~clock_in;
  cst_host i_host (.addr_out(reg_addr_in), .write_out(reg_write_in), .wdata_out(reg_wdata_in),
    .reg_reset_out(register_reset_in));
  cst_regs #(.BLINK_UNIT_CYC(4)) i_cst_regs (.clock_in, .rst_n_in, .clk_en_in, .reg_addr_in,
    .reg_write_in, .reg_wdata_in, .reg_rdata_out, .detect_done_in, .detect_restart_in,
    .detect_reserved_in, .watchdog_expire_in, .register_reset_in, .current_monitor_select_in,
    .charge_voltage_trim_out, .trim_mv_out, .trickle_current_select_out, .trickle_ma_out,
    .input_voltage_limit_offset_out, .offset_mv_out, .status_pin_out, .status_pin_oe_n_out);
  task print_verdict;
    if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // Random traffic against the model, then the pin patterns
  initial begin
    repeat (20) @(posedge clock_in);
    rst_n_in <= 1;
    repeat (3000) begin
      @(posedge clock_in);
      x = $random(seed);
      if (x[1]) x[7:0] = {7'h07, x[0]};
      i_host.op(x[7:0], x[17], x[15:8], x[31:27] == 0);
      {clk_en_in, detect_done_in} <= {x[18:16] != 0, x[21:19] == 0};
      detect_restart_in <= x[24:22] == 0;
      watchdog_expire_in <= x[28:25] == 0;
      detect_reserved_in <= x[30:24];
      // Outputs show the previous cycle's request, so compare before updating the model
      @(negedge clock_in);
      `CHK("rdata", rd, reg_rdata_out)
      `CHK("trim", 6'(tm[tun[7:6]]), trim_mv_out)
      `CHK("trickle", 7'(tun[4] ? 30 : 90), trickle_ma_out)
      `CHK("offset", 14'(om[tun[1:0]]), offset_mv_out)
      `CHK("fields", {tun[7:6], tun[4], tun[1:0]}, fields)
      if (x[18:16] != 0) begin
        rd = x[7:0] == 8'h0E ? {flag, x[30:24]} : x[7:0] == 8'h0F ? tun : 8'h00;
        flag = x[21:19] == 0 ? 1'b1 : x[24:22] == 0 ? 1'b0 : flag;
        tun = x[31:27] == 0 ? 8'h00 : x[28:25] == 0 ? tun & 8'h03
          : x[17] && x[7:0] == 8'h0F ? x[15:8] : tun;
      end
    end
    @(posedge clock_in);
    {clk_en_in, detect_done_in, detect_restart_in, watchdog_expire_in} <= 4'h8;
    for (int i = 0; i < 5; i++) begin
      @(posedge clock_in);
      current_monitor_select_in <= i == 4 ? 2'h2 : 2'h1;
      i_host.op(8'h0F, 1, 8'((i == 4 ? 1 : i) << 2), 0);
      @(posedge clock_in);
      i_host.op(8'h0F, 0, 8'h00, 0);
      repeat (4) @(posedge clock_in);
      cnt = 0;
      repeat (16) begin
        @(negedge clock_in);
        cnt += status_pin_oe_n_out === 1'b0;
      end
      `CHK("led", led[i], cnt)
      `CHK("pin", 1'b0, status_pin_out)
    end
    print_verdict();
  end
endmodule : tb_charger_status_tuning_regs
// Checker beside the register block
bind cst_regs cst_regs_monitor i_mon (.clock_in, .rst_n_in, .clk_en_in, .reg_addr_in,
  .reg_write_in, .reg_wdata_in, .reg_rdata_out, .detect_done_in, .detect_restart_in,
  .detect_reserved_in, .watchdog_expire_in, .register_reset_in, .current_monitor_select_in,
  .charge_voltage_trim_out, .trickle_current_select_out, .input_voltage_limit_offset_out,
  .status_pin_out, .status_pin_oe_n_out);

/* File: verilog/cst_blink.sv */
`timescale 1ns/1ps
// ************************************************
// Status pin pattern generator
// ************************************************
module cst_blink #(
  parameter int UNIT_CYC = cst_pkg::CST_BLINK_UNIT_CYC
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic [1:0] pattern_in,
  output logic led_on_out
);
  import cst_pkg::*;
  logic [31:0] unit_cnt;
  logic [1:0] phase;
  // Unit timebase; phase walks 0..3 seconds for the 1:3 blink, 0..1 for 1:1; 0 is the on slot
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      unit_cnt <= 32'h0;
      phase <= 2'h0;
    end else if (enable_in) begin
      if (pattern_in == CST_PAT_OFF || pattern_in == CST_PAT_ON) begin
        unit_cnt <= 32'h0; // Restart so a new blink opens with a full on second
        phase <= 2'h0;
      end else if (unit_cnt == 32'(UNIT_CYC - 1)) begin
        unit_cnt <= 32'h0;
        if (pattern_in == CST_PAT_BLINK_1_1) begin
          phase <= {1'b0, ~phase[0]};
        end else begin
          phase <= phase + 2'h1;
        end
      end else begin
        unit_cnt <= unit_cnt + 32'h1;
      end
    end
  end
  // Registered LED drive
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      led_on_out <= 1'b0;
    end else if (enable_in) begin
      case (pattern_in)
        CST_PAT_ON: led_on_out <= 1'b1;
        CST_PAT_BLINK_1_1, CST_PAT_BLINK_1_3: led_on_out <= (phase == 2'h0);
        default: led_on_out <= 1'b0;
      endcase
    end
  end
endmodule : cst_blink

/* File: verilog/cst_pkg.sv */
package cst_pkg;
  // ************************************************
  // Register map
  // ************************************************
  localparam logic [7:0] CST_ADDR_DETECT = 8'h0E;
  localparam logic [7:0] CST_ADDR_TUNING = 8'h0F;
  localparam logic [7:0] CST_TUNING_RESET = 8'h00;
  localparam int CST_DONE_BIT = 7;
  localparam int CST_TRIM_LSB = 6;
  localparam int CST_RSVD_BIT = 5;
  localparam int CST_TRICKLE_BIT = 4;
  localparam int CST_PATTERN_LSB = 2;
  localparam int CST_OFFSET_LSB = 0;
  localparam logic [1:0] CST_MON_STATUS = 2'h1;
  // ************************************************
  // Field encodings
  // ************************************************
  localparam logic [1:0] CST_PAT_OFF = 2'h0;
  localparam logic [1:0] CST_PAT_ON = 2'h1;
  localparam logic [1:0] CST_PAT_BLINK_1_1 = 2'h2;
  localparam logic [1:0] CST_PAT_BLINK_1_3 = 2'h3;
  localparam int CST_TRIM_MV_PLUS8 = 8;
  localparam int CST_TRIM_MV_MINUS8 = -8;
  localparam int CST_TRIM_MV_MINUS16 = -16;
  localparam int CST_TRICKLE_MA_DEF = 90;
  localparam int CST_TRICKLE_MA_ALT = 30;
  localparam int CST_OFFSET_MV_0 = 3900;
  localparam int CST_OFFSET_MV_1 = 5900;
  localparam int CST_OFFSET_MV_2 = 7500;
  localparam int CST_OFFSET_MV_3 = 10500;
  // ************************************************
  // Timing
  // ************************************************
  localparam int CST_CLK_HZ = 20000000;
  localparam int CST_BLINK_UNIT_S = 1;
  localparam int CST_BLINK_UNIT_CYC = CST_CLK_HZ * CST_BLINK_UNIT_S;
endpackage : cst_pkg

/* File: verilog/cst_regs.sv */
`timescale 1ns/1ps
// ************************************************
// Detection status and charge tuning registers
// ************************************************
module cst_regs #(
  parameter int BLINK_UNIT_CYC = cst_pkg::CST_BLINK_UNIT_CYC
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_write_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic detect_done_in,
  input wire logic detect_restart_in,
  input wire logic [6:0] detect_reserved_in,
  input wire logic watchdog_expire_in,
  input wire logic register_reset_in,
  input wire logic [1:0] current_monitor_select_in,
  output logic [1:0] charge_voltage_trim_out,
  output logic signed [5:0] trim_mv_out,
  output logic trickle_current_select_out,
  output logic [6:0] trickle_ma_out,
  output logic [1:0] input_voltage_limit_offset_out,
  output logic [13:0] offset_mv_out,
  output logic status_pin_out,
  output logic status_pin_oe_n_out
);
  import cst_pkg::*;

  // ************************************************
  // Local state
  // ************************************************
  // Detection flag; kept out of every reset, so it powers up unknown
  logic source_detect_complete;
  logic next_source_detect_complete;

  // Tuning register image and its next value
  logic [7:0] tuning;
  logic [7:0] next_tuning;

  // Read data about to be registered
  logic [7:0] next_rdata;

  // One hit line per mapped register
  logic addr_hit_detect;
  logic addr_hit_tuning;

  // Qualified update requests for the tuning register
  logic tuning_write;
  logic tuning_clear_all;
  logic tuning_clear_keep_offset;

  // Status pin path; led_on comes from a flip-flop in the generator
  logic [1:0] pattern_field;
  logic led_on;
  logic pattern_active;
  logic pin_drive_low;

  // ************************************************
  // Address decode
  // ************************************************
  // Unmapped addresses hit nothing and read back as zero
  // Decode uses the full eight-bit address, so no aliases appear
  always_comb begin
    addr_hit_detect = 1'b0;
    addr_hit_tuning = 1'b0;
    if (reg_addr_in == CST_ADDR_DETECT) begin
      addr_hit_detect = 1'b1;
    end else if (reg_addr_in == CST_ADDR_TUNING) begin
      addr_hit_tuning = 1'b1;
    end
  end

  // Detection register is read only; a write there is dropped silently,
  // with no error indication, as the host bus has none
  assign tuning_write = reg_write_in & addr_hit_tuning;

  // ************************************************
  // Clear sources
  // ************************************************
  // Both are one-cycle pulses from outside this block
  // Register reset is the stronger clear and also takes the offset field
  assign tuning_clear_all = register_reset_in;

  // Watchdog expiry alone spares the offset field; when both clears
  // meet in one cycle the register reset wins
  assign tuning_clear_keep_offset = watchdog_expire_in & ~register_reset_in;

  // ************************************************
  // Detection done flag
  // ************************************************
  // Done beats a restart in the same cycle, so a finished
  // detection is never lost to a late restart pulse
  always_comb begin
    next_source_detect_complete = source_detect_complete;
    if (detect_done_in) begin
      next_source_detect_complete = 1'b1;
    end else if (detect_restart_in) begin
      next_source_detect_complete = 1'b0;
    end
  end

  // No reset term on purpose: no reset source may clear the flag
  // Bit 7 therefore reads unknown until the first detection event
  always_ff @(posedge clock_in) begin
    if (clk_en_in) begin
      source_detect_complete <= next_source_detect_complete;
    end
  end

  // ************************************************
  // Charge tuning register
  // ************************************************
  // Priority: register reset, then watchdog expiry, then a host write
  // A write that meets a clear is lost; the host must write again
  always_comb begin
    next_tuning = tuning;
    if (tuning_clear_all) begin
      next_tuning = CST_TUNING_RESET;
    end else if (tuning_clear_keep_offset) begin
      // Offset field sits in the low bits and keeps its value
      next_tuning = {CST_TUNING_RESET[7:2], tuning[CST_OFFSET_LSB +: 2]};
    end else if (tuning_write) begin
      next_tuning = reg_wdata_in; // Reserved bit 5 is kept as written
    end
  end

  // All zeros at power-up
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tuning <= CST_TUNING_RESET;
    end else if (clk_en_in) begin
      tuning <= next_tuning;
    end
  end

  // ************************************************
  // Read data path
  // ************************************************
  // Reserved detection bits pass the detector's own undefined value
  // Unmapped reads return zero rather than a stale byte
  always_comb begin
    next_rdata = 8'h00;
    if (addr_hit_detect) begin
      next_rdata = {source_detect_complete, detect_reserved_in};
    end else if (addr_hit_tuning) begin
      next_rdata = tuning;
    end
  end

  // Registered, so the host sees a settled byte one cycle after the address,
  // and the byte holds while the clock enable is low
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (clk_en_in) begin
      reg_rdata_out <= next_rdata;
    end
  end

  // ************************************************
  // Field decodes
  // ************************************************
  // Combinational: the analog side sees a change in the cycle after the write
  // Raw fields and the voltage trim; six signed bits hold -16
  always_comb begin
    charge_voltage_trim_out = tuning[CST_TRIM_LSB +: 2];
    trickle_current_select_out = tuning[CST_TRICKLE_BIT];
    input_voltage_limit_offset_out = tuning[CST_OFFSET_LSB +: 2];
    case (charge_voltage_trim_out)
      2'h1: trim_mv_out = 6'(CST_TRIM_MV_PLUS8);
      2'h2: trim_mv_out = 6'(CST_TRIM_MV_MINUS8);
      2'h3: trim_mv_out = 6'(CST_TRIM_MV_MINUS16);
      default: trim_mv_out = 6'h00;
    endcase
  end

  // Trickle current in milliamps; the default setting is the larger current
  always_comb begin
    trickle_ma_out = trickle_current_select_out ? 7'(CST_TRICKLE_MA_ALT)
                                                 : 7'(CST_TRICKLE_MA_DEF);
  end

  // Input voltage limit offset in millivolts
  always_comb begin
    case (input_voltage_limit_offset_out)
      2'h1: offset_mv_out = 14'(CST_OFFSET_MV_1);
      2'h2: offset_mv_out = 14'(CST_OFFSET_MV_2);
      2'h3: offset_mv_out = 14'(CST_OFFSET_MV_3);
      default: offset_mv_out = 14'(CST_OFFSET_MV_0);
    endcase
  end

  // ************************************************
  // Status pin
  // ************************************************
  // Pattern is only honoured in the status monitor mode
  assign pattern_active = (current_monitor_select_in == CST_MON_STATUS);
  assign pattern_field = tuning[CST_PATTERN_LSB +: 2];

  // Timebase follows the field alone; gating at the pin keeps the
  // blink phase running, at the cost of a mid-blink start when the
  // monitor mode is entered; it shares the register's clock enable
  cst_blink #(
    .UNIT_CYC(BLINK_UNIT_CYC)
  ) i_cst_blink (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .enable_in(clk_en_in),
    .pattern_in(pattern_field),
    .led_on_out(led_on)
  );

  // Open drain: pulls low only while the LED is lit, never drives high
  // Pin sits at high impedance through reset
  assign pin_drive_low = pattern_active & led_on;
  assign status_pin_out = 1'b0;
  assign status_pin_oe_n_out = ~pin_drive_low;
endmodule : cst_regs
